// *** sync_burst_sram_defs.svh ***
`ifndef SYNC_BURST_SRAM_DEFS_SVH
`define SYNC_BURST_SRAM_DEFS_SVH

// ==========================================================
// array geometry
`define SBS_ADDR_W     17
`define SBS_DEPTH      131072
`define SBS_LANES      4
`define SBS_LANE_W     9
`define SBS_DATA_W     36

// ==========================================================
// burst counter
`define SBS_CNT_W      2
`define SBS_CNT_STEP   2'h1

// ==========================================================
// reset values
`define SBS_ADDR_RST   17'h00000
`define SBS_CNT_RST    2'h0
`define SBS_DATA_RST   36'h000000000
`define SBS_LANES_RST  4'h0

`endif

// *** sync_burst_sram_pkg.sv ***
`include "sync_burst_sram_defs.svh"

package sync_burst_sram_pkg;

	// burst state, one-hot
	typedef enum logic [2:0] {
		BURST_IDLE  = 3'h1,
		BURST_READ  = 3'h2,
		BURST_WRITE = 3'h4
	} burst_state_e;

	typedef logic [`SBS_DATA_W-1:0] word_t;
	typedef logic [`SBS_LANES-1:0]  lanes_t;

	// replace the lanes that are enabled, keep the others
	function automatic word_t mergeLanes(
		input word_t  oldWord,
		input word_t  newWord,
		input lanes_t lanes
	);
		word_t result;
		result = oldWord;
		for (int i = 0; i < `SBS_LANES; i++) begin
			if (lanes[i]) begin
				result[i*`SBS_LANE_W +: `SBS_LANE_W] =
					newWord[i*`SBS_LANE_W +: `SBS_LANE_W];
			end
		end
		return result;
	endfunction

endpackage

// *** burst_addr_gen.sv ***
`timescale 1ns/10ps
`include "sync_burst_sram_defs.svh"

// ==========================================================
// burst address: only the two lowest bits move
module burst_addr_gen (
	// loaded start address and step
	input  wire logic [`SBS_ADDR_W-1:0] baseAddr,
	input  wire logic [`SBS_CNT_W-1:0]  step,
	input  wire logic                   interleave,
	// resulting word address
	output logic      [`SBS_ADDR_W-1:0] burstAddr
);

	logic [`SBS_CNT_W-1:0] linearLow;
	logic [`SBS_CNT_W-1:0] interLow;
	logic [`SBS_CNT_W-1:0] chosenLow;

	// wraps modulo four, upper bits never carry
	assign linearLow = baseAddr[`SBS_CNT_W-1:0] + step;
	assign interLow  = baseAddr[`SBS_CNT_W-1:0] ^ step;
	assign chosenLow = interleave ? interLow : linearLow;
	assign burstAddr = {baseAddr[`SBS_ADDR_W-1:`SBS_CNT_W], chosenLow};

endmodule

// *** byte_lane_array.sv ***
`timescale 1ns/10ps
`include "sync_burst_sram_defs.svh"

// ==========================================================
// storage array, one write port, one combinational read port
module byte_lane_array (
	// clock
	input  wire logic                   clock,
	// write port
	input  wire logic                   writeEn,
	input  wire logic [`SBS_ADDR_W-1:0] writeAddr,
	input  wire logic [`SBS_LANES-1:0]  writeLanes,
	input  wire logic [`SBS_DATA_W-1:0] writeData,
	// read port
	input  wire logic [`SBS_ADDR_W-1:0] readAddr,
	output logic      [`SBS_DATA_W-1:0] readData
);

	// contents are not reset, as in a real array
	logic [`SBS_DATA_W-1:0] mem [0:`SBS_DEPTH-1];

	logic [`SBS_DATA_W-1:0] oldWord;
	logic [`SBS_DATA_W-1:0] newWord;

	assign oldWord  = mem[writeAddr];
	assign newWord  = sync_burst_sram_pkg::mergeLanes(oldWord, writeData,
		writeLanes);
	assign readData = mem[readAddr];

	always_ff @(posedge clock) begin
		if (writeEn) begin
			mem[writeAddr] <= newWord;
		end
	end

endmodule

// *** sync_burst_sram_port.sv ***
`timescale 1ns/10ps
`include "sync_burst_sram_defs.svh"

// ==========================================================
// sync_burst_sram_port
// Function
// - address captured only on selected enabled load
// - selected load starts a fresh access
// - deselected load ends any running burst
// - advance steps the burst counter
// - address inputs ignored during advance
// - data transfer one cycle after load
// - clock enable high freezes everything
// - each 9-bit lane has own write enable
// - lane enables ignored when reading
// - lanes written with next-cycle data
// - any chip select false gives deselect
// - pins undriven one cycle after deselect
// - high select mirrors low selects inverted
// - everything but output enable on rising edge
// - write data registered, read data flow-through
// - burst order pin picks interleaved or linear
// - output enable high forces pins undriven
// - one address yields four data cycles

module sync_burst_sram_port (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	// address and control
	input  wire logic [`SBS_ADDR_W-1:0] addressInputs,
	input  wire logic                   advanceOrLoad,
	input  wire logic                   readNotWrite,
	input  wire logic                   clockEnable_n,
	input  wire logic [`SBS_LANES-1:0]  byteWriteEnables_n,
	// chip selects
	input  wire logic                   chipSelectA_n,
	input  wire logic                   chipSelectB_n,
	input  wire logic                   chipSelectHigh,
	// static strap and output enable
	input  wire logic                   burstOrderSelect,
	input  wire logic                   outputEnable_n,
	// data pins, split three ways
	input  wire logic [`SBS_DATA_W-1:0] dataPinsIn,
	output logic      [`SBS_DATA_W-1:0] dataPinsOut,
	output logic                        dataPinsOe
);

	// ==========================================================
	// input decode

	logic cycleEn;
	logic chipSelected;
	logic loadCycle;
	logic deselectCycle;
	logic advanceCycle;
	logic loadRead;
	logic loadWrite;

	// a stalled edge is treated as if it never happened
	assign cycleEn       = ~clockEnable_n;

	assign chipSelected  = ~chipSelectA_n
		& ~chipSelectB_n
		& chipSelectHigh;

	assign loadCycle     = cycleEn & ~advanceOrLoad & chipSelected;
	assign deselectCycle = cycleEn & ~advanceOrLoad & ~chipSelected;
	assign advanceCycle  = cycleEn & advanceOrLoad;

	assign loadRead      = loadCycle & readNotWrite;
	assign loadWrite     = loadCycle & ~readNotWrite;

	// ==========================================================
	// burst state

	sync_burst_sram_pkg::burst_state_e state_r;
	sync_burst_sram_pkg::burst_state_e state_nxt;

	logic burstActive;
	logic advanceRead;
	logic advanceWrite;

	assign burstActive  = (state_r != sync_burst_sram_pkg::BURST_IDLE);
	assign advanceRead  = advanceCycle
		& (state_r == sync_burst_sram_pkg::BURST_READ);
	assign advanceWrite = advanceCycle
		& (state_r == sync_burst_sram_pkg::BURST_WRITE);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sync_burst_sram_pkg::BURST_IDLE: begin
				if (loadRead) begin
					state_nxt = sync_burst_sram_pkg::BURST_READ;
				end else if (loadWrite) begin
					state_nxt = sync_burst_sram_pkg::BURST_WRITE;
				end
			end
			sync_burst_sram_pkg::BURST_READ,
			sync_burst_sram_pkg::BURST_WRITE: begin
				if (loadRead) begin
					state_nxt = sync_burst_sram_pkg::BURST_READ;
				end else if (loadWrite) begin
					state_nxt = sync_burst_sram_pkg::BURST_WRITE;
				end else if (deselectCycle) begin
					state_nxt = sync_burst_sram_pkg::BURST_IDLE;
				end
			end
			default: begin
				state_nxt = sync_burst_sram_pkg::BURST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_r <= sync_burst_sram_pkg::BURST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// address register and burst counter

	logic [`SBS_ADDR_W-1:0] baseAddr_r;
	logic [`SBS_CNT_W-1:0]  count_r;
	logic [`SBS_CNT_W-1:0]  count_nxt;
	logic [`SBS_ADDR_W-1:0] burstAddr;
	logic                   stepBurst;

	// the counter wraps after the fourth word, so a longer
	// advance run revisits the same four words
	assign stepBurst = advanceCycle & burstActive;
	assign count_nxt = count_r + `SBS_CNT_STEP;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			baseAddr_r <= `SBS_ADDR_RST;
		end else if (loadCycle) begin
			baseAddr_r <= addressInputs;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			count_r <= `SBS_CNT_RST;
		end else if (loadCycle) begin
			count_r <= `SBS_CNT_RST;
		end else if (stepBurst) begin
			count_r <= count_nxt;
		end
	end

	// address of the next burst word, from the loaded base
	burst_addr_gen u_burstAddr (
		.baseAddr   (baseAddr_r),
		.step       (count_nxt),
		.interleave (burstOrderSelect),
		.burstAddr  (burstAddr)
	);

	// ==========================================================
	// access address for this edge

	logic [`SBS_ADDR_W-1:0] accessAddr;
	logic                   accessRead;
	logic                   accessWrite;
	logic [`SBS_LANES-1:0]  accessLanes;

	// a load takes the pins, an advance only the counter
	assign accessAddr  = loadCycle ? addressInputs : burstAddr;
	assign accessRead  = loadRead | advanceRead;
	assign accessWrite = loadWrite | advanceWrite;

	// lane enables count only when a write is issued
	assign accessLanes = accessWrite ? ~byteWriteEnables_n
		: `SBS_LANES_RST;

	// ==========================================================
	// pending data cycle

	logic                   xferWrite_r;
	logic [`SBS_ADDR_W-1:0] xferAddr_r;
	logic [`SBS_LANES-1:0]  xferLanes_r;
	logic                   commitWrite;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			xferWrite_r <= 1'b0;
		end else if (cycleEn) begin
			xferWrite_r <= accessWrite;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			xferAddr_r  <= `SBS_ADDR_RST;
			xferLanes_r <= `SBS_LANES_RST;
		end else if (cycleEn) begin
			xferAddr_r  <= accessAddr;
			xferLanes_r <= accessLanes;
		end
	end

	// write data is taken on the edge that closes the data cycle
	assign commitWrite = cycleEn & xferWrite_r;

	// ==========================================================
	// storage

	logic [`SBS_DATA_W-1:0] arrayData;

	byte_lane_array u_array (
		.clock      (clock),
		.writeEn    (commitWrite),
		.writeAddr  (xferAddr_r),
		.writeLanes (xferLanes_r),
		.writeData  (dataPinsIn),
		.readAddr   (accessAddr),
		.readData   (arrayData)
	);

	// ==========================================================
	// read path

	logic                   bypassHit;
	logic [`SBS_DATA_W-1:0] readWord;
	logic [`SBS_DATA_W-1:0] readData_r;
	logic                   driveRead_r;
	logic                   driveRead_nxt;

	// a read issued on the edge that retires a write to the same
	// word must see the new lanes, or back-to-back use breaks
	assign bypassHit = commitWrite & (xferAddr_r == accessAddr);
	assign readWord  = bypassHit
		? sync_burst_sram_pkg::mergeLanes(arrayData, dataPinsIn,
			xferLanes_r)
		: arrayData;

	// the word is fetched at the issuing edge so the pins carry it
	// through the data cycle without a further output stage
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			readData_r <= `SBS_DATA_RST;
		end else if (cycleEn && accessRead) begin
			readData_r <= readWord;
		end
	end

	// writes and deselects release the pins one cycle later
	assign driveRead_nxt = accessRead;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			driveRead_r <= 1'b0;
		end else if (cycleEn) begin
			driveRead_r <= driveRead_nxt;
		end
	end

	// ==========================================================
	// pins

	// output enable is the only path that bypasses the clock
	assign dataPinsOut = readData_r;
	assign dataPinsOe  = driveRead_r & ~outputEnable_n;

endmodule

// *** sync_burst_sram_port_assertions.sv ***
`timescale 1ns/10ps
`include "sync_burst_sram_defs.svh"

// ==========================================================
// port checker
module sync_burst_sram_port_assertions (
	// clock and reset
	input wire logic                   clock,
	input wire logic                   rst_b,
	// control
	input wire logic                   advanceOrLoad,
	input wire logic                   readNotWrite,
	input wire logic                   clockEnable_n,
	input wire logic                   chipSelectA_n,
	input wire logic                   chipSelectB_n,
	input wire logic                   chipSelectHigh,
	input wire logic                   outputEnable_n,
	// data
	input wire logic [`SBS_DATA_W-1:0] dataPinsOut,
	input wire logic                   dataPinsOe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	wire sel   = !chipSelectA_n && !chipSelectB_n && chipSelectHigh;
	wire go    = !clockEnable_n;
	wire rd    = go && !advanceOrLoad && sel && readNotWrite;
	wire wr    = go && !advanceOrLoad && sel && !readNotWrite;
	wire desel = go && !advanceOrLoad && !sel;
	wire adv   = go && advanceOrLoad;

	a_oe_forces_float: assert property (outputEnable_n |-> !dataPinsOe)
		else $error("pins driven with output enable high");
	a_read_next: assert property (rd |=> dataPinsOe || outputEnable_n)
		else $error("read data missing in data cycle");
	a_write_quiet: assert property (wr |=> !dataPinsOe)
		else $error("pins driven after write load");
	a_desel_float: assert property (desel |=> !dataPinsOe)
		else $error("pins driven after deselect");
	a_stall_data: assert property (!go |=> $stable(dataPinsOut))
		else $error("read data moved on disabled edge");
	a_stall_enable: assert property (
		!go ##1 $stable(outputEnable_n) |-> $stable(dataPinsOe))
		else $error("drive moved on disabled edge");
	a_idle_advance: assert property (desel ##1 adv |=> !dataPinsOe)
		else $error("advance after deselect drove pins");
	a_read_burst: assert property (
		rd ##1 adv |=> dataPinsOe || outputEnable_n)
		else $error("read burst stopped on advance");
	a_write_burst: assert property (wr ##1 adv |=> !dataPinsOe)
		else $error("write burst drove pins");

	c_read_burst: cover property (rd ##1 adv);
	c_turnaround: cover property (wr ##1 rd);
	c_deselect: cover property (desel);
	c_stall: cover property (!go ##1 !go);
endmodule

bind sync_burst_sram_port sync_burst_sram_port_assertions
	i_sync_burst_sram_port_assertions (
	.clock, .rst_b, .advanceOrLoad, .readNotWrite, .clockEnable_n,
	.chipSelectA_n, .chipSelectB_n, .chipSelectHigh, .outputEnable_n,
	.dataPinsOut, .dataPinsOe
);

// *** sram_controller_model.sv ***
`timescale 1ns/10ps
`include "sync_burst_sram_defs.svh"

// ==========================================================
// controller side of the shared data pins
module sram_controller_model (
	// clock
	input  wire logic                   clock,
	// device side
	input  wire logic [`SBS_DATA_W-1:0] dataPinsOut,
	input  wire logic                   dataPinsOe,
	// write data cycle from the bench
	input  wire logic [`SBS_DATA_W-1:0] wrData,
	input  wire logic                   wrDrive,
	// resolved pin level
	output logic      [`SBS_DATA_W-1:0] pins
);
	logic [`SBS_DATA_W-1:0] last_r = '0;

	// undriven pins toggle so a stale level never passes for data
	assign pins = dataPinsOe ? dataPinsOut : wrDrive ? wrData : ~last_r;
	always_ff @(posedge clock) last_r <= pins;
endmodule

// *** sync_burst_sram_port_test.sv ***
`timescale 1ns/10ps
`include "sync_burst_sram_defs.svh"

`define CHK(got, exp) begin \
	totalChecks++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("[FAIL] %0t got %h exp %h", $time, got, exp); \
	end \
end

module sync_burst_sram_port_test;
	logic        clock = 0, rst_b = 0, advanceOrLoad = 1, readNotWrite = 1;
	logic        clockEnable_n = 0, chipSelectA_n = 0, chipSelectB_n = 0;
	logic        chipSelectHigh = 1, burstOrderSelect = 0;
	logic        outputEnable_n = 0, wrDrive = 0;
	logic [16:0] addressInputs = '0;
	logic [3:0]  byteWriteEnables_n = '0;
	logic [35:0] wrData = '0;
	wire  [35:0] dataPinsIn, dataPinsOut;
	wire         dataPinsOe;
	int          mismatches = 0, totalChecks = 0, cycles = 0;

	sync_burst_sram_port i_sync_burst_sram_port (.clock, .rst_b,
		.addressInputs, .advanceOrLoad, .readNotWrite, .clockEnable_n,
		.byteWriteEnables_n, .chipSelectA_n, .chipSelectB_n,
		.chipSelectHigh, .burstOrderSelect, .outputEnable_n, .dataPinsIn,
		.dataPinsOut, .dataPinsOe);
	sram_controller_model i_sram_controller_model (.clock, .dataPinsOut,
		.dataPinsOe, .wrData, .wrDrive, .pins(dataPinsIn));

	// ==========================================================
	// helpers
	initial forever #2 clock = ~clock;

	function automatic logic [35:0] pat(input logic [16:0] a);
		pat = {a, 2'h3, a};
	endfunction

	function automatic logic [16:0] ba(input logic [16:0] b, input int k);
		ba = {b[16:2], burstOrderSelect ? b[1:0] ^ k[1:0] : b[1:0] + k[1:0]};
	endfunction

	// one cycle; write data is released at the edge that takes it
	task automatic op(input bit ld, rnw, input logic [16:0] a,
		input logic [3:0] ln, input logic [35:0] d, input bit drv);
		advanceOrLoad = !ld;
		readNotWrite = rnw;
		addressInputs = a;
		byteWriteEnables_n = ln;
		wrData = d;
		wrDrive = drv;
		@(posedge clock);
		wrDrive <= 0;
		#1;
	endtask

	// strap only moves while the port is held in reset
	task automatic rst(input logic ord);
		rst_b = 0;
		burstOrderSelect = ord;
		repeat (16) @(posedge clock);
		#1 rst_b = 1;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_burst(input logic ord, input logic [16:0] wb, rb);
		rst(ord);
		`CHK(dataPinsOe, 1'h0)
		op(1, 0, wb, 4'h0, '0, 0);
		for (int k = 0; k < 3; k++)
			op(0, 0, ~wb, 4'h0, pat(ba(wb, k)), 1);
		op(1, 1, rb, 4'hF, pat(ba(wb, 3)), 1);
		for (int k = 0; k < 5; k++) begin
			`CHK(dataPinsIn, pat(ba(rb, k)))
			if (k < 4) op(0, 0, ~rb, 4'h0, '0, 0);
		end
	endtask

	task automatic t_lanes;
		op(1, 0, 17'h00040, 4'h0, '0, 0);
		op(1, 0, 17'h00040, 4'hA, pat(17'h00040), 1);
		op(1, 1, 17'h00040, 4'h0, ~pat(17'h00040), 1);
		`CHK(dataPinsIn, pat(17'h00040) ^ 36'h007FC01FF)
	endtask

	task automatic t_stall;
		logic [35:0] m;
		m = pat(17'h00040) ^ 36'h007FC01FF;
		op(1, 1, 17'h00040, 4'h0, '0, 0);
		`CHK(dataPinsIn, m)
		clockEnable_n = 1;
		repeat (3) begin
			op(1, 0, 17'h00021, 4'h0, '0, 0);
			`CHK(dataPinsIn, m)
		end
		advanceOrLoad = 1;
		outputEnable_n = 1;
		#1 `CHK(dataPinsOe, 1'h0)
		// output enable stays high across a stalled edge
		@(posedge clock);
		#1 `CHK(dataPinsOe, 1'h0)
		outputEnable_n = 0;
		clockEnable_n = 0;
		#1 `CHK(dataPinsIn, m)
		@(posedge clock);
		#1;
	endtask

	task automatic t_selects;
		for (int i = 0; i < 3; i++) begin
			op(1, 1, 17'h00021, 4'h0, '0, 0);
			`CHK(dataPinsOe, 1'h1)
			{chipSelectA_n, chipSelectB_n, chipSelectHigh} = 3'h1 ^ (3'h4 >> i);
			op(1, 1, 17'h00021, 4'h0, '0, 0);
			`CHK(dataPinsOe, 1'h0)
			{chipSelectA_n, chipSelectB_n, chipSelectHigh} = 3'h1;
			op(0, 1, 17'h00021, 4'h0, '0, 0);
			`CHK(dataPinsOe, 1'h0)
		end
	endtask

	// ==========================================================
	// closing
	task automatic complete_run;
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles > 2000) begin
			mismatches++;
			complete_run;
		end
	end

	initial begin
		t_burst(0, 17'h00021, 17'h00022);
		t_burst(1, 17'h00131, 17'h00133);
		t_lanes;
		t_stall;
		t_selects;
		complete_run;
	end
endmodule
